// [cke_pwr_ctrl.sv]
// controller side: drives clock enable and commands, keeps exit delays
`default_nettype none
module cke_pwr_ctrl #(
    parameter int unsigned XSDLL = cke_pwr_pkg::T_XSDLL
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // user requests
    input  wire logic                cmd_valid,
    input  wire logic [2:0]          cmd_code,
    input  wire logic                cmd_a10,
    input  wire logic                pd_req,
    input  wire logic                sr_req,
    input  wire logic                wake_req,
    input  wire logic                odt_req,
    output logic                     cmd_ready,
    output logic                     in_low_power,
    // link
    cke_pwr_if.ctrl                  link
);
    logic [cke_pwr_pkg::CNT_W-1:0] hold_q;
    logic [cke_pwr_pkg::CNT_W-1:0] xs_q;
    logic [cke_pwr_pkg::CNT_W-1:0] dll_q;
    logic [cke_pwr_pkg::CNT_W-1:0] wr_q;
    logic [cke_pwr_pkg::CNT_W-1:0] bsy_q;
    logic                          in_sr_q;
    logic                          open_q;
    logic                          allow;
    logic                          sr_ok;

    // a command is allowed when link awake and exit delays are met
    always_comb begin
        allow = link.cke && hold_q == cke_pwr_pkg::CNT_ZERO
                && xs_q == cke_pwr_pkg::CNT_ZERO;
        if (cmd_code == 3'(cke_pwr_pkg::CMD_RD) && dll_q != cke_pwr_pkg::CNT_ZERO)
            allow = 1'b0;
        if (cmd_code == 3'(cke_pwr_pkg::CMD_WR) && wr_q != cke_pwr_pkg::CNT_ZERO)
            allow = 1'b0;
        // self refresh only once banks are closed and the last command has finished
        sr_ok = sr_req && !open_q && bsy_q == cke_pwr_pkg::CNT_ZERO;
    end

    // cke, command pins and delay counters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.cke   <= 1'b1;
            link.cs_b  <= 1'b1;
            link.ras_b <= 1'b1;
            link.cas_b <= 1'b1;
            link.we_b  <= 1'b1;
            link.a10   <= 1'b0;
            link.odt   <= 1'b0;
            hold_q     <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_MOD);
            xs_q       <= cke_pwr_pkg::CNT_ZERO;
            dll_q      <= cke_pwr_pkg::CNT_ZERO;
            wr_q       <= cke_pwr_pkg::CNT_ZERO;
            bsy_q      <= cke_pwr_pkg::CNT_ZERO;
            in_sr_q    <= 1'b0;
            open_q     <= 1'b0;
        end else begin
            link.cs_b <= 1'b1; // default deselect
            link.odt  <= odt_req && !in_sr_q && dll_q == cke_pwr_pkg::CNT_ZERO;
            if (hold_q != cke_pwr_pkg::CNT_ZERO) hold_q <= hold_q - cke_pwr_pkg::CNT_ONE;
            if (xs_q != cke_pwr_pkg::CNT_ZERO) xs_q <= xs_q - cke_pwr_pkg::CNT_ONE;
            if (dll_q != cke_pwr_pkg::CNT_ZERO) dll_q <= dll_q - cke_pwr_pkg::CNT_ONE;
            if (wr_q != cke_pwr_pkg::CNT_ZERO) wr_q <= wr_q - cke_pwr_pkg::CNT_ONE;
            // busy window is frozen while cke is low, as in the memory
            if (bsy_q != cke_pwr_pkg::CNT_ZERO && link.cke) bsy_q <= bsy_q - cke_pwr_pkg::CNT_ONE;
            if (!link.cke) begin
                if (wake_req && hold_q == cke_pwr_pkg::CNT_ZERO) begin
                    link.cke <= 1'b1;
                    hold_q   <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_CKE_MIN);
                    if (in_sr_q) begin
                        xs_q  <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_XS);
                        dll_q <= cke_pwr_pkg::CNT_W'(XSDLL);
                        wr_q  <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_WR_SRX);
                    end else begin
                        xs_q  <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_XP);
                    end
                    in_sr_q <= 1'b0;
                end
            end else if (allow && (sr_ok || pd_req)) begin
                link.cke <= 1'b0;
                hold_q   <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_CKE_MIN);
                if (sr_ok) begin
                    link.cs_b  <= 1'b0;
                    link.ras_b <= 1'b0;
                    link.cas_b <= 1'b0;
                    link.we_b  <= 1'b1;
                    in_sr_q    <= 1'b1;
                    link.odt   <= 1'b0;
                end
            end else if (allow && cmd_valid) begin
                link.cs_b  <= 1'b0;
                {link.ras_b, link.cas_b, link.we_b} <= cmd_code;
                link.a10   <= cmd_a10;
                bsy_q      <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_BURST);
                if (cmd_code == 3'(cke_pwr_pkg::CMD_ACT)) open_q <= 1'b1;
                if (cmd_code == 3'(cke_pwr_pkg::CMD_PRE) && cmd_a10) open_q <= 1'b0;
                if (cmd_code == 3'(cke_pwr_pkg::CMD_MRS))
                    hold_q <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_MOD);
            end
        end
    end

    // status flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ready    <= 1'b0;
            in_low_power <= 1'b0;
        end else begin
            cmd_ready    <= allow && !sr_req && !pd_req;
            in_low_power <= !link.cke;
        end
    end
endmodule
`default_nettype wire

// [cke_pwr_device.sv]
// memory-side power-state tracker driven by clock enable and commands
`default_nettype none
module cke_pwr_device (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // link
    cke_pwr_if.mem                   link,
    // state view
    output var  cke_pwr_pkg::pwr_state_t state,
    output logic                     banks_open,
    output logic                     refresh_busy,
    output logic                     odt_active,
    output logic                     illegal_seen
);
    logic                       cke_prev_q;
    logic                       open_q;
    logic                       busy_q;
    logic [cke_pwr_pkg::CNT_W-1:0] busy_cnt_q;
    cke_pwr_pkg::pwr_state_t    st_q;
    cke_pwr_pkg::cmd_t          cmd;
    logic                       nop_like;
    logic                       bank_close;

    // deselect counts as nop; a10 high on precharge closes all banks
    always_comb begin
        cmd        = cke_pwr_pkg::cmd_t'({link.ras_b, link.cas_b, link.we_b});
        nop_like   = link.cs_b || (cmd == cke_pwr_pkg::CMD_NOP);
        bank_close = !link.cs_b && cmd == cke_pwr_pkg::CMD_PRE && link.a10;
    end

    // previous-edge clock enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cke_prev_q <= 1'b1; // matches the controller's cke level in reset
        end else begin
            cke_prev_q <= link.cke;
        end
    end

    // busy window for bursts, precharge and refresh
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_q <= cke_pwr_pkg::CNT_ZERO;
        end else if (cke_prev_q && link.cke && !nop_like) begin
            busy_cnt_q <= cke_pwr_pkg::CNT_W'(cke_pwr_pkg::T_BURST);
        end else if (busy_cnt_q != cke_pwr_pkg::CNT_ZERO && link.cke) begin
            busy_cnt_q <= busy_cnt_q - cke_pwr_pkg::CNT_ONE;
        end
    end

    always_comb busy_q = (busy_cnt_q != cke_pwr_pkg::CNT_ZERO);

    // bank open tracking; frozen in power-down so exit restores it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            open_q <= 1'b0;
        end else if (cke_prev_q && link.cke && !link.cs_b) begin
            if (cmd == cke_pwr_pkg::CMD_ACT) begin
                open_q <= 1'b1;
            end else if (bank_close) begin
                open_q <= 1'b0;
            end
        end
    end

    // power-state machine: prior state, cke(n-1), cke(n), command(n)
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q         <= cke_pwr_pkg::ST_IDLE;
            illegal_seen <= 1'b0;
        end else begin
            case (st_q)
                cke_pwr_pkg::ST_PPD, cke_pwr_pkg::ST_APD: begin
                    if (link.cke) begin
                        if (!nop_like) illegal_seen <= 1'b1;
                        st_q <= open_q ? cke_pwr_pkg::ST_ACTIVE
                                       : cke_pwr_pkg::ST_IDLE;
                    end
                end
                cke_pwr_pkg::ST_SREF: begin
                    if (link.cke) begin
                        st_q <= cke_pwr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    if (cke_prev_q && !link.cke) begin
                        if (!link.cs_b && cmd == cke_pwr_pkg::CMD_REF
                            && !open_q && !busy_q) begin
                            st_q <= cke_pwr_pkg::ST_SREF;
                        end else begin
                            if (!nop_like) illegal_seen <= 1'b1;
                            st_q <= (open_q && !bank_close) ? cke_pwr_pkg::ST_APD
                                                            : cke_pwr_pkg::ST_PPD;
                        end
                    end else if (busy_q) begin
                        st_q <= cke_pwr_pkg::ST_BUSY;
                    end else begin
                        st_q <= open_q ? cke_pwr_pkg::ST_ACTIVE
                                       : cke_pwr_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // state outputs; no refresh in power-down, termination off in self refresh
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= cke_pwr_pkg::ST_IDLE;
            banks_open   <= 1'b0;
            refresh_busy <= 1'b0;
            odt_active   <= 1'b0;
        end else begin
            state        <= st_q;
            banks_open   <= open_q;
            refresh_busy <= (st_q == cke_pwr_pkg::ST_SREF);
            odt_active   <= link.odt && st_q != cke_pwr_pkg::ST_SREF;
        end
    end
endmodule
`default_nettype wire

// [cke_pwr_if.sv]
// link between controller and memory: clock enable, command pins, termination
`default_nettype none
interface cke_pwr_if;
    logic       cke;
    logic       cs_b;
    logic       ras_b;
    logic       cas_b;
    logic       we_b;
    logic       a10;
    logic       odt;

    modport ctrl (output cke, cs_b, ras_b, cas_b, we_b, a10, odt);
    modport mem  (input  cke, cs_b, ras_b, cas_b, we_b, a10, odt);
endinterface
`default_nettype wire

// [cke_pwr_pkg.sv]
// constants and types shared by both ends of the clock-enable power-state link
// What this block does
// - sample cke and command on rising edge
// - controller waits mode-register delays before cke low
// - action from prior state, two cke levels, command
// - cke low twice: hold state, ignore pins
// - only nop/deselect on power-down cke edges
// - only nop/deselect on self-refresh exit edge
// - nop/deselect throughout self-refresh exit delay
// - no read or termination before long exit delay
// - first write 512 clocks after self-refresh exit
// - self refresh only from idle, refresh with cke fall
// - no self-refresh request during read or write
// - power-down kind follows banks closed or open
// - no refresh while powered down
// - hold cke level until minimum pulse met
// - idle needs banks closed, no burst, cke high, delays done (the memory side reports ST_IDLE on exit before exit delays end)
// - termination ignored for cke, off in self refresh
// - controller avoids unlisted combinations
// - other states use only legal commands
// - deselect behaves exactly like nop
// - self-refresh exit seen on cke level alone
`default_nettype none
package cke_pwr_pkg;
    // command encoding {ras_b, cas_b, we_b} with cs_b low
    typedef enum logic [2:0] {
        CMD_MRS = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR  = 3'h4,
        CMD_RD  = 3'h5,
        CMD_ZQ  = 3'h6,
        CMD_NOP = 3'h7
    } cmd_t;

    // device power state
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ACTIVE = 3'h1,
        ST_BUSY   = 3'h2,
        ST_PPD    = 3'h3,
        ST_APD    = 3'h4,
        ST_SREF   = 3'h5,
        ST_EXIT   = 3'h6
    } pwr_state_t;

    // timing counts in memory clocks
    localparam int unsigned T_MOD     = 12;
    localparam int unsigned T_MRD     = 4;
    localparam int unsigned T_CKE_MIN = 3;
    localparam int unsigned T_XP      = 3;
    localparam int unsigned T_XS      = 24;
    localparam int unsigned T_XSDLL   = 512;
    localparam int unsigned T_WR_SRX  = 512;
    localparam int unsigned T_BURST   = 4;
    localparam int unsigned CNT_W     = 10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;
endpackage
`default_nettype wire

// [cke_pwr_sva.sv]
// assertions on the clock-enable power-state link
`default_nettype none
module cke_pwr_sva #(
    parameter int unsigned XSDLL = cke_pwr_pkg::T_XSDLL
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic a10,
    input wire logic odt
);
    logic [2:0] op;
    logic       nop;
    logic       fall;
    logic       rise;
    logic       sre;
    logic       cke_q;
    logic       sr_q;
    logic       bank_q;
    logic [9:0] xs_q;
    logic [9:0] dll_q;
    logic [9:0] wr_q;
    logic [9:0] xp_q;
    logic [9:0] mod_q;
    logic [9:0] bst_q;

    // command decode and cke edges
    assign op   = {ras_b, cas_b, we_b};
    assign nop  = cs_b | (op == 3'h7);
    assign fall = cke_q & !cke;
    assign rise = !cke_q & cke;
    assign sre  = fall & !cs_b & (op == 3'h1);

    function automatic logic [9:0] dec(input logic [9:0] v);
        return v - {9'h000, v != 10'h000};
    endfunction

    // cke history, self-refresh and bank tracking
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cke_q  <= 1'b1;
            sr_q   <= 1'b0;
            bank_q <= 1'b0;
        end else begin
            cke_q <= cke;
            if (sre) begin
                sr_q <= 1'b1;
            end else if (rise) begin
                sr_q <= 1'b0;
            end
            if (cke && !cs_b && op == 3'h3) begin
                bank_q <= 1'b1;
            end else if (cke && !cs_b && op == 3'h2 && a10) begin
                bank_q <= 1'b0;
            end
        end
    end

    // delay counters after exits, mode-register sets and bursts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {xs_q, dll_q, wr_q} <= '0;
            {xp_q, mod_q, bst_q} <= '0;
        end else begin
            xs_q  <= (rise && sr_q) ? 10'(cke_pwr_pkg::T_XS - 1) : dec(xs_q);
            dll_q <= (rise && sr_q) ? 10'(XSDLL - 1) : dec(dll_q);
            wr_q  <= (rise && sr_q) ? 10'(cke_pwr_pkg::T_WR_SRX - 1) : dec(wr_q);
            xp_q  <= (rise && !sr_q) ? 10'(cke_pwr_pkg::T_XP - 1) : dec(xp_q);
            mod_q <= (cke && !cs_b && op == 3'h0) ? 10'(cke_pwr_pkg::T_MOD - 1) : dec(mod_q);
            bst_q <= (cke && !cs_b && op[2:1] == 2'h2) ? 10'(cke_pwr_pkg::T_BURST) : dec(bst_q);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    rise_quiet_a: assert property (rise |-> nop)
        else $error("command on cke rise");
    fall_quiet_a: assert property (fall |-> nop || sre)
        else $error("command on cke fall");
    hold_high_a: assert property ($rose(cke) |=> cke [*2])
        else $error("cke high too short");
    hold_low_a: assert property ($fell(cke) |=> !cke [*2])
        else $error("cke low too short");
    xs_quiet_a: assert property (xs_q != 10'h000 |-> nop)
        else $error("command inside exit delay");
    dll_read_a: assert property (dll_q != 10'h000 |-> nop || op != 3'h5)
        else $error("read before long exit delay");
    dll_odt_a: assert property (dll_q != 10'h000 |-> !odt)
        else $error("termination before long exit delay");
    wr_wait_a: assert property (wr_q != 10'h000 |-> nop || op != 3'h4)
        else $error("write too soon after exit");
    mrs_gap_a: assert property (mod_q != 10'h000 |-> !fall)
        else $error("cke low too soon after mode set");
    sr_idle_a: assert property (sre |-> !bank_q && bst_q == 10'h000)
        else $error("self refresh entered while busy");
    xp_quiet_a: assert property (xp_q != 10'h000 |-> nop)
        else $error("command inside power-down exit");

    cover property (sre);
    cover property (rise && sr_q);
    cover property (fall && !sre && bank_q);
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench joining controller and memory ends
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int XS = 40;
    typedef struct packed {
        logic                    act;
        logic                    sr;
        cke_pwr_pkg::pwr_state_t low;
        cke_pwr_pkg::pwr_state_t back;
    } row_t;
    row_t rows [3] = '{
        '{1'b0, 1'b0, cke_pwr_pkg::ST_PPD, cke_pwr_pkg::ST_IDLE},
        '{1'b1, 1'b0, cke_pwr_pkg::ST_APD, cke_pwr_pkg::ST_ACTIVE},
        '{1'b0, 1'b1, cke_pwr_pkg::ST_SREF, cke_pwr_pkg::ST_IDLE}};
    logic                    clk = 1'b0;
    logic                    rst_b = 1'b0;
    logic                    cmd_valid = 1'b0;
    logic [2:0]              cmd_code = 3'h7;
    logic                    cmd_a10 = 1'b0;
    logic                    pd_req = 1'b0;
    logic                    sr_req = 1'b0;
    logic                    wake_req = 1'b0;
    logic                    odt_req = 1'b1;
    logic                    cmd_ready;
    logic                    in_low_power;
    cke_pwr_pkg::pwr_state_t state;
    logic                    banks_open;
    logic                    refresh_busy;
    logic                    odt_active;
    logic                    illegal_seen;
    int                      fails = 0;
    int                      checks_done = 0;
    int                      waited;
    int                      r;
    cke_pwr_if               lnk ();

    cke_pwr_ctrl #(.XSDLL(XS)) cke_pwr_ctrl_i (.clk(clk), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_a10(cmd_a10), .pd_req(pd_req),
        .sr_req(sr_req), .wake_req(wake_req), .odt_req(odt_req), .cmd_ready(cmd_ready),
        .in_low_power(in_low_power), .link(lnk.ctrl));
    cke_pwr_device cke_pwr_device_i (.clk(clk), .rst_b(rst_b), .link(lnk.mem),
        .state(state), .banks_open(banks_open), .refresh_busy(refresh_busy),
        .odt_active(odt_active), .illegal_seen(illegal_seen));
    cke_pwr_sva #(.XSDLL(XS)) cke_pwr_sva_i (.clk(clk), .rst_b(rst_b), .cke(lnk.cke),
        .cs_b(lnk.cs_b), .ras_b(lnk.ras_b), .cas_b(lnk.cas_b), .we_b(lnk.we_b),
        .a10(lnk.a10), .odt(lnk.odt));

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic cyc();
        @(posedge clk);
        #5;
    endtask

    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // bounded wait for cmd_ready (pwr low) or in_low_power (pwr high) to reach a level
    task automatic wait_on(input logic pwr, input logic v);
        waited = 0;
        while ((pwr ? in_low_power : cmd_ready) !== v && waited < 2000) begin
            cyc();
            waited++;
        end
        if ((pwr ? in_low_power : cmd_ready) !== v) begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic send(input logic [2:0] c, input logic a);
        cmd_code = c;
        cmd_a10 = a;
        cyc();
        wait_on(1'b0, 1'b1);
        cmd_valid = 1'b1;
        cyc();
        cmd_valid = 1'b0;
    endtask

    task automatic enter(input logic sr);
        {sr_req, pd_req} = {sr, !sr};
        wait_on(1'b1, 1'b1);
        {sr_req, pd_req} = 2'h0;
        repeat (2) cyc();
    endtask

    task automatic leave();
        wake_req = 1'b1;
        wait_on(1'b1, 1'b0);
        wake_req = 1'b0;
    endtask

    initial begin
        repeat (3) cyc();
        rst_b = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (rows[i].act) send(cke_pwr_pkg::CMD_ACT, 1'b0);
            enter(rows[i].sr);
            check(state, rows[i].low);
            check({2'h0, refresh_busy}, {2'h0, rows[i].sr});
            check({2'h0, cmd_ready}, 3'h0);
            check({2'h0, odt_active}, {2'h0, !rows[i].sr});
            leave();
            cmd_code = cke_pwr_pkg::CMD_ACT;
            wait_on(1'b0, 1'b1);
            repeat (2) cyc();
            check(state, rows[i].back);
            check({2'h0, odt_active}, {2'h0, !rows[i].sr});
            if (rows[i].act) send(cke_pwr_pkg::CMD_PRE, 1'b1);
        end
        // read and write held off after self-refresh exit
        enter(1'b1);
        leave();
        cmd_code = cke_pwr_pkg::CMD_RD;
        wait_on(1'b0, 1'b1);
        r = waited;
        check({2'h0, r + 2 >= XS}, 3'h1);
        send(cke_pwr_pkg::CMD_WR, 1'b0);
        check({2'h0, r + waited + 2 >= cke_pwr_pkg::T_WR_SRX}, 3'h1);
        // power-down requested right after a mode-register set
        send(cke_pwr_pkg::CMD_MRS, 1'b0);
        enter(1'b0);
        check({2'h0, waited > cke_pwr_pkg::T_MOD}, 3'h1);
        leave();
        check({2'h0, illegal_seen}, 3'h0);
        // reset in mid-run with a bank open
        send(cke_pwr_pkg::CMD_ACT, 1'b0);
        repeat (2) cyc();
        check({2'h0, banks_open}, 3'h1);
        rst_b = 1'b0;
        cyc();
        check(state, cke_pwr_pkg::ST_IDLE);
        check({banks_open, refresh_busy, in_low_power}, 3'h0);
        rst_b = 1'b1;
        repeat (2) cyc();
        check(state, cke_pwr_pkg::ST_IDLE);
        check({cmd_ready, banks_open, in_low_power}, 3'h0);
        repeat (2) cyc();
        wrap_up();
    end
endmodule
`default_nettype wire
